//--- hw/fcp_flash_ctrl.sv
`timescale 1ns/100ps
`include "fcp_params.svh"
// Overview of operation
// - Select pin high gives programmer mode; low or open gives hub mode.
// - Row phase gives A[18:11], column phase gives A[10:0].
// - Output enable low reads, write strobe low writes; data bus off otherwise.
// - Hub mode picks read or write from start nibble bits 0 and 1.
// - Reset low halts everything and releases every output.
// - After reset the device resumes read or standby from control pins.
// - Boot lock strap low at power-on blocks boot block program and erase.
// - Write-protect strap low at power-on blocks all other sectors.
// - Identification read of 7FFF2 shows inverted lock straps on bits 2, 3.
// - Three-byte or single-byte exit command leaves identification mode.
// - Sector erase needs six writes: unlock, unlock, setup, unlock, unlock, erase.
// - Sector address latched on select rise; 30H latched on strobe rise.
// - Erase needs no preprogramming, spares other sectors, times itself.
// - Erase starts at last strobe rise; ends with poll bit 1, read mode.
// - Byte programming only clears bits; only erase sets them again.
// - Four-write sequence starts byte program right after the last write.
// - Internal timer ends program after about 12 us, back to read.
// - Data polling and toggle status show end of program or erase.
// - Array is eight 64K-byte sectors, each erasable alone.
// - Sector erase is internally timed at about 0.6 s.
// - Each read while busy inverts toggle bit; it stops when done.
// - Exceeded limit sets timeout bit until a hardware reset.
// - Ready/busy pin low while busy, released when ready.
module fcp_flash_ctrl
   import fcp_pkg::*;
#(
   parameter int ERASE_CYCLES = `FCP_ERASE_CYCLES,
   parameter logic [7:0] MFR_CODE = 8'h11,  // Arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h22   // Arbitrary value
) (
   input  wire logic           core_clk_in,
   input  wire logic           sys_rst_in,
   input  wire logic           reset_n_in,
   input  wire logic           interface_select_pin_in,
   input  wire logic           top_boot_lock_n_in,
   input  wire logic           write_protect_n_in,
   input  wire fcp_pgm_pins_t  pgm_pins_in,
   input  wire logic           hub_cycle_start_in,
   input  wire logic [3:0]     hub_address_data_lanes_in,
   input  wire logic [7:0]     array_rdata_in,
   output logic [7:0]          dq_out,
   output logic                dq_oe_out,
   output logic                ready_busy_n_out,
   output logic                ready_busy_n_oe_out,
   output fcp_array_req_t      array_req_out,
   output logic                hub_read_out,
   output logic                hub_write_out,
   output logic                pgm_mode_out
);

   fcp_state_t        state_q;
   logic              straps_valid_q;
   logic              boot_locked_q;
   logic              wp_locked_q;
   logic              mode_pgm_q;
   logic [7:0]        row_q;
   logic [10:0]       col_q;
   logic [18:0]       tgt_addr_q;
   logic [7:0]        tgt_data_q;
   logic              id_mode_q;
   logic              toggle_q;
   logic              timeout_q;
   logic              op_erase_q;
   logic              rc_prev_q;
   logic              we_prev_q;
   logic              oe_prev_q;
   logic              tmr_load;
   logic [`FCP_TIMER_W-1:0] tmr_val;
   logic              tmr_done;
   logic              halt;
   logic              pgm_active;
   logic              wr_stb;
   logic              rd_stb;
   logic              busy;
   logic [18:0]       wr_addr;
   logic [7:0]        wr_data;
   logic              unlock_a;
   logic              unlock_b;
   logic              sect_prot;
   logic [7:0]        status_byte;
   logic [18:0]       rd_addr;

   // Device reset halts all activity
   assign halt = ~reset_n_in;

   // Programmer logic acts only in programmer mode
   assign pgm_active = mode_pgm_q & ~halt;

   // Write taken on strobe rise, inhibited while output enable low
   assign wr_stb = pgm_active & pgm_pins_in.we_n & ~we_prev_q & pgm_pins_in.oe_n;
   assign rd_stb = pgm_active & ~pgm_pins_in.oe_n & oe_prev_q;

   assign busy = (state_q == ST_BUSY_PROG) || (state_q == ST_BUSY_ERASE) ||
                 (state_q == ST_BUSY_PROT);

   // Full internal address from row and column phases
   assign wr_addr  = {row_q, col_q};
   assign rd_addr  = {row_q, pgm_pins_in.addr};
   assign wr_data  = pgm_pins_in.dq;
   assign unlock_a = (wr_addr[14:0] == `FCP_UNLOCK_ADDR_A) && (wr_data == `FCP_UNLOCK_DATA_A);
   assign unlock_b = (wr_addr[14:0] == `FCP_UNLOCK_ADDR_B) && (wr_data == `FCP_UNLOCK_DATA_B);

   // Hardware lock by sector
   always_comb begin
      if (wr_addr[`FCP_SECTOR_MSB:`FCP_SECTOR_LSB] == `FCP_BOOT_SECTOR) begin
         sect_prot = boot_locked_q;
      end else begin
         sect_prot = wp_locked_q;
      end
   end

   // Status byte returned while an operation runs
   always_comb begin
      status_byte = 8'h00;
      status_byte[`FCP_POLL_POS]    = op_erase_q ? 1'b0 : ~tgt_data_q[7];
      status_byte[`FCP_TOGGLE_POS]  = toggle_q;
      status_byte[`FCP_TIMEOUT_POS] = timeout_q;
   end

   // Straps caught once after power-on, mode also at reset release
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         straps_valid_q <= 1'b0;
         boot_locked_q  <= 1'b0;
         wp_locked_q    <= 1'b0;
         mode_pgm_q     <= 1'b0;
      end else begin
         if (!straps_valid_q) begin
            straps_valid_q <= 1'b1;
            boot_locked_q  <= ~top_boot_lock_n_in;
            wp_locked_q    <= ~write_protect_n_in;
         end
         if (!straps_valid_q || halt) begin
            mode_pgm_q <= interface_select_pin_in;
         end
      end
   end

   // Strobe history for edge detection
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rc_prev_q <= 1'b0;
         we_prev_q <= 1'b1;
         oe_prev_q <= 1'b1;
      end else begin
         rc_prev_q <= pgm_pins_in.row_col_sel;
         we_prev_q <= pgm_pins_in.we_n;
         oe_prev_q <= pgm_pins_in.oe_n;
      end
   end

   // Row latched on select rise, column on strobe fall
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || halt) begin
         row_q <= 8'h00;
         col_q <= 11'h000;
      end else if (pgm_active) begin
         if (pgm_pins_in.row_col_sel && !rc_prev_q) begin
            row_q <= pgm_pins_in.addr[7:0];
         end
         if (!pgm_pins_in.we_n && we_prev_q) begin
            col_q <= pgm_pins_in.addr;
         end
      end
   end

   // Command sequencer
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || halt) begin
         state_q    <= ST_IDLE;
         id_mode_q  <= 1'b0;
         tgt_addr_q <= 19'h00000;
         tgt_data_q <= 8'h00;
         op_erase_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE, ST_UNLK1, ST_UNLK2, ST_ERS_UNLK0, ST_ERS_UNLK1, ST_ERS_CMD,
            ST_PROG_DATA: begin
               if (wr_stb) begin
                  if (state_q == ST_PROG_DATA) begin
                     tgt_addr_q <= wr_addr;
                     tgt_data_q <= wr_data;
                     op_erase_q <= 1'b0;
                     state_q    <= sect_prot ? ST_BUSY_PROT : ST_BUSY_PROG;
                  end else if (wr_data == `FCP_CMD_ID_EXIT) begin
                     id_mode_q <= 1'b0;
                     state_q   <= ST_IDLE;
                  end else if (state_q == ST_IDLE) begin
                     state_q <= unlock_a ? ST_UNLK1 : ST_IDLE;
                  end else if (state_q == ST_UNLK1) begin
                     state_q <= unlock_b ? ST_UNLK2 : ST_IDLE;
                  end else if (state_q == ST_UNLK2) begin
                     if (wr_addr[14:0] != `FCP_UNLOCK_ADDR_A) begin
                        state_q <= ST_IDLE;
                     end else if (wr_data == `FCP_CMD_PROGRAM) begin
                        state_q <= ST_PROG_DATA;
                     end else if (wr_data == `FCP_CMD_ERASE_SETUP) begin
                        state_q <= ST_ERS_UNLK0;
                     end else if (wr_data == `FCP_CMD_ID_ENTRY) begin
                        id_mode_q <= 1'b1;
                        state_q   <= ST_IDLE;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end else if (state_q == ST_ERS_UNLK0) begin
                     state_q <= unlock_a ? ST_ERS_UNLK1 : ST_IDLE;
                  end else if (state_q == ST_ERS_UNLK1) begin
                     state_q <= unlock_b ? ST_ERS_CMD : ST_IDLE;
                  end else if (wr_data == `FCP_CMD_SECTOR_ERASE) begin
                     tgt_addr_q <= wr_addr;
                     tgt_data_q <= 8'hff;
                     op_erase_q <= 1'b1;
                     state_q    <= sect_prot ? ST_BUSY_PROT : ST_BUSY_ERASE;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_BUSY_PROG: begin
               if (tmr_done) begin
                  // Programming a 1 over a stored 0 cannot succeed
                  if (|(tgt_data_q & ~array_rdata_in)) begin
                     state_q <= ST_FAIL;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_BUSY_ERASE, ST_BUSY_PROT: begin
               if (tmr_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_FAIL: begin
               state_q <= ST_FAIL;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Timer load on entry to each timed state
   always_comb begin
      tmr_load = 1'b0;
      tmr_val  = '0;
      if (wr_stb && (state_q == ST_PROG_DATA || state_q == ST_ERS_CMD)) begin
         if (sect_prot && (state_q == ST_PROG_DATA || wr_data == `FCP_CMD_SECTOR_ERASE)) begin
            tmr_load = 1'b1;
            tmr_val  = `FCP_TIMER_W'(`FCP_PROT_CYCLES);
         end else if (state_q == ST_PROG_DATA) begin
            tmr_load = 1'b1;
            tmr_val  = `FCP_TIMER_W'(`FCP_PROG_CYCLES);
         end else if (wr_data == `FCP_CMD_SECTOR_ERASE) begin
            tmr_load = 1'b1;
            tmr_val  = `FCP_TIMER_W'(ERASE_CYCLES);
         end
      end
   end

   fcp_op_timer #(
      .W           (`FCP_TIMER_W)
   ) u_timer (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .load_in     (tmr_load),
      .load_val_in (tmr_val),
      .abort_in    (halt),
      .busy_out    (),
      .done_out    (tmr_done)
   );

   // Toggle and timeout status
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || halt) begin
         toggle_q  <= 1'b0;
         timeout_q <= 1'b0;
      end else begin
         if (rd_stb && (busy || state_q == ST_FAIL)) begin
            toggle_q <= ~toggle_q;
         end
         if (state_q == ST_BUSY_PROG && tmr_done && |(tgt_data_q & ~array_rdata_in)) begin
            timeout_q <= 1'b1;
         end
      end
   end

   // Array requests: program clears bits only, erase whole sector
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || halt) begin
         array_req_out <= '0;
      end else begin
         array_req_out.addr  <= (busy || state_q == ST_FAIL) ? tgt_addr_q : rd_addr;
         array_req_out.wdata <= tgt_data_q & array_rdata_in;
         array_req_out.prog  <= (state_q == ST_BUSY_PROG) && tmr_done &&
                                !(|(tgt_data_q & ~array_rdata_in));
         array_req_out.erase <= (state_q == ST_BUSY_ERASE) && tmr_done;
      end
   end

   // Read data and data bus enable
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || halt) begin
         dq_out    <= 8'h00;
         dq_oe_out <= 1'b0;
      end else begin
         dq_oe_out <= pgm_active & ~pgm_pins_in.oe_n & pgm_pins_in.we_n;
         if (busy || state_q == ST_FAIL) begin
            dq_out <= status_byte;
         end else if (id_mode_q && rd_addr == `FCP_ID_LOCK_ADDR) begin
            dq_out <= 8'h00;
            dq_out[`FCP_BOOT_SENSE_POS] <= boot_locked_q;
            dq_out[`FCP_PROT_SENSE_POS] <= wp_locked_q;
         end else if (id_mode_q && rd_addr == `FCP_ID_MFR_ADDR) begin
            dq_out <= MFR_CODE;
         end else if (id_mode_q && rd_addr == `FCP_ID_DEV_ADDR) begin
            dq_out <= DEV_CODE;
         end else begin
            dq_out <= array_rdata_in;
         end
      end
   end

   // Open-drain ready/busy driven low only while busy
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || halt) begin
         ready_busy_n_out    <= 1'b1;
         ready_busy_n_oe_out <= 1'b0;
      end else begin
         ready_busy_n_out    <= 1'b0;
         ready_busy_n_oe_out <= mode_pgm_q & busy;
      end
   end

   // Hub start nibble decode
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || halt) begin
         hub_read_out  <= 1'b0;
         hub_write_out <= 1'b0;
         pgm_mode_out  <= 1'b0;
      end else begin
         pgm_mode_out  <= mode_pgm_q;
         hub_read_out  <= !mode_pgm_q && hub_cycle_start_in &&
                          hub_address_data_lanes_in[0] && !hub_address_data_lanes_in[1];
         hub_write_out <= !mode_pgm_q && hub_cycle_start_in &&
                          hub_address_data_lanes_in[1] && !hub_address_data_lanes_in[0];
      end
   end

endmodule : fcp_flash_ctrl

//--- hw/fcp_op_timer.sv
`timescale 1ns/100ps
module fcp_op_timer
   import fcp_pkg::*;
#(
   parameter int W = 26
) (
   input  wire logic         core_clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] load_val_in,
   input  wire logic         abort_in,
   output logic              busy_out,
   output logic              done_out
);

   logic [W-1:0] count_q;

   // Down counter, done pulses on the last count
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || abort_in) begin
         count_q  <= '0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else if (load_in) begin
         count_q  <= load_val_in;
         busy_out <= 1'b1;
         done_out <= 1'b0;
      end else if (busy_out) begin
         count_q  <= count_q - W'(1);
         done_out <= (count_q == W'(1));
         busy_out <= (count_q != W'(1));
      end else begin
         done_out <= 1'b0;
      end
   end

endmodule : fcp_op_timer

//--- hw/fcp_params.svh
`ifndef FCP_PARAMS_SVH
`define FCP_PARAMS_SVH

// Clock and internally timed operations
`define FCP_CLK_PERIOD_NS    10
`define FCP_PROG_TIME_NS     12000
`define FCP_PROG_CYCLES      (`FCP_PROG_TIME_NS / `FCP_CLK_PERIOD_NS)
`define FCP_PROT_TIME_NS     1000
`define FCP_PROT_CYCLES      (`FCP_PROT_TIME_NS / `FCP_CLK_PERIOD_NS)
`define FCP_ERASE_TIME_MS    600
`define FCP_ERASE_CYCLES     (`FCP_ERASE_TIME_MS * 1000000 / `FCP_CLK_PERIOD_NS)
`define FCP_TIMER_W          26

// Command sequence addresses and codes
`define FCP_UNLOCK_ADDR_A    15'h5555
`define FCP_UNLOCK_ADDR_B    15'h2aaa
`define FCP_UNLOCK_DATA_A    8'haa
`define FCP_UNLOCK_DATA_B    8'h55
`define FCP_CMD_PROGRAM      8'ha0
`define FCP_CMD_ERASE_SETUP  8'h80
`define FCP_CMD_SECTOR_ERASE 8'h30
`define FCP_CMD_ID_ENTRY     8'h90
`define FCP_CMD_ID_EXIT      8'hf0

// Identification mode read addresses
`define FCP_ID_MFR_ADDR      19'h00000
`define FCP_ID_DEV_ADDR      19'h00001
`define FCP_ID_LOCK_ADDR     19'h7fff2

// Sector layout and status bit positions
`define FCP_BOOT_SECTOR      3'h7
`define FCP_SECTOR_MSB       18
`define FCP_SECTOR_LSB       16
`define FCP_POLL_POS         7
`define FCP_TOGGLE_POS       6
`define FCP_TIMEOUT_POS      5
`define FCP_PROT_SENSE_POS   3
`define FCP_BOOT_SENSE_POS   2

`endif

//--- hw/fcp_pkg.sv
package fcp_pkg;

   // Command sequencer states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_UNLK1,
      ST_UNLK2,
      ST_ERS_UNLK0,
      ST_ERS_UNLK1,
      ST_ERS_CMD,
      ST_PROG_DATA,
      ST_BUSY_PROG,
      ST_BUSY_ERASE,
      ST_BUSY_PROT,
      ST_FAIL
   } fcp_state_t;

   // Programmer mode pin group
   typedef struct packed {
      logic        row_col_sel;
      logic [10:0] addr;
      logic [7:0]  dq;
      logic        oe_n;
      logic        we_n;
   } fcp_pgm_pins_t;

   // Request to the storage array
   typedef struct packed {
      logic [18:0] addr;
      logic [7:0]  wdata;
      logic        prog;
      logic        erase;
   } fcp_array_req_t;

endpackage : fcp_pkg

//--- tb/fcp_array_model.sv
`timescale 1ns/100ps
module fcp_array_model
   import fcp_pkg::*;
(
   input  wire logic           core_clk_in,
   input  wire fcp_array_req_t req_in,
   output logic [7:0]          rdata_out
);
   logic [7:0] mem_q [0:524287];

   // Array starts fully erased
   initial begin
      foreach (mem_q[i]) begin
         mem_q[i] = 8'hff;
      end
   end

   // Reply for the requested byte
   assign rdata_out = mem_q[req_in.addr];

   // Byte stored as given, erase of one whole sector
   always @(posedge core_clk_in) begin
      if (req_in.prog) begin
         mem_q[req_in.addr] <= req_in.wdata;
      end
      if (req_in.erase) begin
         for (int i = 0; i < 65536; i++) begin
            mem_q[{req_in.addr[18:16], i[15:0]}] <= 8'hff;
         end
      end
   end
endmodule : fcp_array_model

//--- tb/fcp_flash_ctrl_sva.sv
`timescale 1ns/100ps
`include "fcp_params.svh"
module fcp_flash_ctrl_sva
   import fcp_pkg::*;
#(
   parameter int ERASE_CYCLES = 50
) (
   input wire logic           core_clk_in,
   input wire logic           sys_rst_in,
   input wire logic           reset_n_in,
   input wire logic           interface_select_pin_in,
   input wire fcp_pgm_pins_t  pgm_pins_in,
   input wire logic           hub_cycle_start_in,
   input wire logic [3:0]     hub_address_data_lanes_in,
   input wire logic [7:0]     array_rdata_in,
   input wire logic           dq_oe_out,
   input wire logic           ready_busy_n_oe_out,
   input wire fcp_array_req_t array_req_out,
   input wire logic           hub_read_out,
   input wire logic           hub_write_out,
   input wire logic           pgm_mode_out
);
   localparam int PROG_LO  = `FCP_PROG_CYCLES - 10;
   localparam int PROG_HI  = `FCP_PROG_CYCLES + 10;
   localparam int ERASE_LO = ERASE_CYCLES - 10;
   localparam int ERASE_HI = ERASE_CYCLES + 10;
   logic [31:0] busy_cnt_q;
   logic [7:0]  we_age_q;
   logic        we_prev_q;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   // Consecutive cycles with the busy line pulled
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in || !ready_busy_n_oe_out) begin
         busy_cnt_q <= 32'h00000000;
      end else if (busy_cnt_q != 32'hffffffff) begin
         busy_cnt_q <= busy_cnt_q + 32'h00000001;
      end
   end

   // Cycles since the last rising write strobe
   always_ff @(posedge core_clk_in) begin
      we_prev_q <= pgm_pins_in.we_n;
      if (sys_rst_in || (pgm_pins_in.we_n && !we_prev_q)) begin
         we_age_q <= 8'h00;
      end else if (we_age_q != 8'hff) begin
         we_age_q <= we_age_q + 8'h01;
      end
   end

   bus_release_a: assert property (
      pgm_pins_in.oe_n |=> !dq_oe_out)
      else $error("data bus driven with output enable high");
   halt_outputs_a: assert property (
      !reset_n_in |=> !dq_oe_out && !ready_busy_n_oe_out)
      else $error("outputs driven during hardware reset");
   read_resume_a: assert property (
      reset_n_in && pgm_mode_out && !pgm_pins_in.oe_n |=> dq_oe_out)
      else $error("no read drive with output enable low");
   mode_capture_a: assert property (
      $fell(sys_rst_in) |-> ##2 pgm_mode_out == $past(interface_select_pin_in, 2))
      else $error("mode not taken from select pin");
   hub_read_a: assert property (
      hub_read_out |-> $past(hub_cycle_start_in)
         && $past(hub_address_data_lanes_in[1:0]) == 2'b01)
      else $error("hub read without read start nibble");
   hub_write_a: assert property (
      reset_n_in && !pgm_mode_out && !interface_select_pin_in && hub_cycle_start_in
         && hub_address_data_lanes_in[1:0] == 2'b10 |=> hub_write_out)
      else $error("hub write start nibble not decoded");
   busy_start_a: assert property (
      $rose(ready_busy_n_oe_out) |-> we_age_q <= 8'h04)
      else $error("busy began late after final strobe");
   prog_time_a: assert property (
      array_req_out.prog |-> busy_cnt_q >= PROG_LO && busy_cnt_q <= PROG_HI)
      else $error("program time off");
   erase_time_a: assert property (
      array_req_out.erase |-> busy_cnt_q >= ERASE_LO && busy_cnt_q <= ERASE_HI)
      else $error("erase time off");
   prog_clear_a: assert property (
      array_req_out.prog |-> (array_req_out.wdata & ~array_rdata_in) == 8'h00)
      else $error("program would raise a bit");
endmodule : fcp_flash_ctrl_sva

bind fcp_flash_ctrl fcp_flash_ctrl_sva #(.ERASE_CYCLES(ERASE_CYCLES)) u_sva (
   .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reset_n_in(reset_n_in),
   .interface_select_pin_in(interface_select_pin_in), .pgm_pins_in(pgm_pins_in),
   .hub_cycle_start_in(hub_cycle_start_in), .array_rdata_in(array_rdata_in),
   .hub_address_data_lanes_in(hub_address_data_lanes_in), .dq_oe_out(dq_oe_out),
   .ready_busy_n_oe_out(ready_busy_n_oe_out), .array_req_out(array_req_out),
   .hub_read_out(hub_read_out), .hub_write_out(hub_write_out), .pgm_mode_out(pgm_mode_out)
);

//--- tb/fcp_tb.sv
`timescale 1ns/100ps
`include "fcp_params.svh"
module tb;
   import fcp_pkg::*;
   localparam int ERASE_N = 50;
   localparam logic [7:0] ID_MFR = 8'h3b; // Arbitrary value
   localparam logic [7:0] ID_DEV = 8'h6e; // Arbitrary value
   logic           core_clk_in, sys_rst_in, reset_n_in, sel, tbl_n, wp_n, hub_start;
   logic           dq_oe, rb_n, rb_oe, rb_line, hub_rd, hub_wr, pgm_mode;
   logic [3:0]     lanes;
   logic [7:0]     rdata, dq, got, prev;
   fcp_pgm_pins_t  drv, pins;
   fcp_array_req_t req;
   int             err_total = 0;
   int             comparisons = 0;
   int             cyc = 0;
   int             n;

`define CHK(act, exp) \
   begin \
      comparisons++; \
      if ((act) !== (exp)) begin \
         err_total++; \
         $display("unexpected at %0t: got %0h expected %0h", $time, act, exp); \
      end \
   end

   // Shared data bus and pulled-up ready line
   always_comb begin
      pins = drv;
      if (dq_oe) begin
         pins.dq = dq;
      end
   end
   assign rb_line = rb_oe ? rb_n : 1'b1;

   fcp_flash_ctrl #(.ERASE_CYCLES(ERASE_N), .MFR_CODE(ID_MFR), .DEV_CODE(ID_DEV)) DUT (
      .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reset_n_in(reset_n_in),
      .interface_select_pin_in(sel), .top_boot_lock_n_in(tbl_n),
      .write_protect_n_in(wp_n), .pgm_pins_in(pins), .hub_cycle_start_in(hub_start),
      .hub_address_data_lanes_in(lanes), .array_rdata_in(rdata), .dq_out(dq),
      .dq_oe_out(dq_oe), .ready_busy_n_out(rb_n), .ready_busy_n_oe_out(rb_oe),
      .array_req_out(req), .hub_read_out(hub_rd), .hub_write_out(hub_wr),
      .pgm_mode_out(pgm_mode)
   );
   fcp_array_model u_array (.core_clk_in(core_clk_in), .req_in(req), .rdata_out(rdata));

   // 100 MHz clock
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   // Cycle ceiling against a hang
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic step(input int k);
      repeat (k) @(posedge core_clk_in);
      #1;
   endtask : step

   task automatic power_on();
      sys_rst_in = 1'b1;
      step(4);
      sys_rst_in = 1'b0;
      step(2);
   endtask : power_on

   task automatic set_row(input logic [18:0] a);
      drv.row_col_sel = 1'b0;
      drv.addr = {3'h0, a[18:11]};
      step(1);
      drv.row_col_sel = 1'b1;
      step(1);
      drv.addr = a[10:0];
   endtask : set_row

   task automatic wr(input logic [18:0] a, input logic [7:0] d);
      set_row(a);
      drv.dq = d;
      drv.we_n = 1'b0;
      step(1);
      drv.we_n = 1'b1;
      step(1);
      drv.dq = ~d;
   endtask : wr

   task automatic rd(input logic [18:0] a);
      set_row(a);
      drv.oe_n = 1'b0;
      step(3);
      got = pins.dq;
      `CHK(dq_oe, 1'b1)
      drv.oe_n = 1'b1;
      step(1);
   endtask : rd

   task automatic unlock();
      wr(19'h05555, 8'haa);
      wr(19'h02aaa, 8'h55);
   endtask : unlock

   task automatic prog(input logic [18:0] a, input logic [7:0] d);
      unlock();
      wr(19'h05555, 8'ha0);
      wr(a, d);
      step(2);
   endtask : prog

   task automatic wait_ready();
      n = 0;
      while (rb_line !== 1'b1 && n < 3000) begin
         step(1);
         n++;
      end
   endtask : wait_ready

   // Main sequence
   initial begin
      drv = '{row_col_sel: 1'b0, addr: 11'h000, dq: 8'h00, oe_n: 1'b1, we_n: 1'b1};
      reset_n_in = 1'b1;
      sel = 1'b1;
      tbl_n = 1'b1;
      wp_n = 1'b1;
      hub_start = 1'b0;
      lanes = 4'h0;
      power_on();
      `CHK(dq_oe, 1'b0)
      `CHK(rb_line, 1'b1)
      `CHK(pgm_mode, 1'b1)
      // Byte program in two sectors, polled, with a command while busy
      for (int s = 0; s < 2; s++) begin
         prog({s[2:0], 16'h1234}, 8'h5a);
         `CHK(rb_line, 1'b0)
         rd({s[2:0], 16'h1234});
         prev = got;
         `CHK(got[7], 1'b1)
         rd(19'h7abcd);
         `CHK(got[6], ~prev[6])
         prog(19'h21234, 8'h00);
         wait_ready();
         `CHK(n > `FCP_PROG_CYCLES - 80 && n < `FCP_PROG_CYCLES + 10, 1'b1)
         rd({s[2:0], 16'h1234});
         `CHK(got, 8'h5a)
      end
      rd(19'h21234);
      `CHK(got, 8'hff)
      // Raising a cleared bit ends in the timeout state until reset
      prog(19'h11234, 8'hff);
      step(1300);
      rd(19'h11234);
      `CHK(got[5], 1'b1)
      reset_n_in = 1'b0;
      drv.oe_n = 1'b0;
      step(2);
      `CHK({dq_oe, rb_oe}, 2'b00)
      reset_n_in = 1'b1;
      step(3);
      `CHK(dq_oe, 1'b1)
      drv.oe_n = 1'b1;
      rd(19'h11234);
      `CHK(got, 8'h5a)
      // Erase of sector 0 leaves sector 1 alone
      unlock();
      wr(19'h05555, 8'h80);
      unlock();
      wr(19'h00000, 8'h30);
      step(2);
      `CHK(rb_line, 1'b0)
      rd(19'h01234);
      `CHK(got[7], 1'b0)
      wait_ready();
      `CHK(n < ERASE_N + 10, 1'b1)
      rd(19'h01234);
      `CHK(got, 8'hff)
      rd(19'h11234);
      `CHK(got, 8'h5a)
      // Lock straps at power-on, identification read, both exit forms
      for (int k = 0; k < 2; k++) begin
         tbl_n = k[0];
         wp_n = ~k[0];
         power_on();
         unlock();
         wr(19'h05555, 8'h90);
         rd(19'h7fff2);
         `CHK(got[3:2], {k[0], ~k[0]})
         rd(19'h00000);
         `CHK(got, ID_MFR)
         rd(19'h00001);
         `CHK(got, ID_DEV)
         if (k == 1) begin
            unlock();
         end
         wr(19'h05555, 8'hf0);
         rd(19'h00000);
         `CHK(got, 8'hff)
         prog({3'h7, 15'h0000, k[0]}, 8'h3c);
         wait_ready();
         `CHK(n < `FCP_PROT_CYCLES + 20, ~k[0])
         prog({3'h3, 15'h0000, k[0]}, 8'h3c);
         wait_ready();
         rd({3'h7, 15'h0000, k[0]});
         `CHK(got, k[0] ? 8'h3c : 8'hff)
         rd({3'h3, 15'h0000, k[0]});
         `CHK(got, k[0] ? 8'hff : 8'h3c)
      end
      // Hub mode decode of the start nibble
      sel = 1'b0;
      power_on();
      `CHK(pgm_mode, 1'b0)
      for (int k = 1; k < 3; k++) begin
         lanes = k[3:0];
         hub_start = 1'b1;
         step(1);
         `CHK({hub_wr, hub_rd}, k[1:0])
         hub_start = 1'b0;
         step(1);
      end
      test_done();
   end
endmodule : tb
